// [rtl/iecc_regs.vh]
/*
 Constants for the interface code generator: register offsets, field
 positions, reset values and block sizes.
 Assumes inclusion by the design files only; defines nothing else.
*/
// Contract
// - Code covers bytes crossing master or FIFO path
// - Two configurations chosen by one mode bit
// - Mode zero gives one code per 256 bytes, two in all
// - First block to first result, next to second
// - Mode zero freezes both results after second
// - Any restart write clears and begins anew
// - Mode one gives one code per 512 bytes
// - Mode one fills first result, second unused
// - Mode one holds first result until restart
// - Code corrects single, detects double bit errors
// - Per endpoint width bit; generator needs bytes; code has one CTRL width bit for all traffic
`ifndef IECC_REGS_VH
`define IECC_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define IECC_ADDR_CTRL    12'h000
`define IECC_ADDR_RESTART 12'h004
`define IECC_ADDR_FIRST   12'h008
`define IECC_ADDR_SECOND  12'h00C
`define IECC_ADDR_STATUS  12'h010
`define IECC_ADDR_BITS    12

// ----------------------------------------
// Fields
// ----------------------------------------
`define IECC_CTRL_MODE_BIT  0
`define IECC_CTRL_WIDE_BIT  1
`define IECC_STAT_FIRST_BIT 0
`define IECC_STAT_DONE_BIT  1
`define IECC_CTRL_RESET     2'h0

// ----------------------------------------
// Block sizes and code layout
// ----------------------------------------
`define IECC_BLOCK_SHORT 10'h100
`define IECC_BLOCK_LONG  10'h200
`define IECC_LAST_SHORT  9'h0FF
`define IECC_LAST_LONG   9'h1FF
`define IECC_CODE_W      24
`define IECC_HTRANS_NSEQ 2'h2

`endif

// [rtl/iecc_parity.v]
/*
 Line and column parity accumulator for one block of bytes.
 Assumes one byte per enable pulse with its index inside the block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iecc_regs.vh"

module iecc_parity #(
   parameter IDX_W = 9
) (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire clear,
   input wire take,
   input wire [IDX_W-1:0] idx,
   input wire [7:0] data,
   output wire [2*IDX_W+5:0] code
);

// ----------------------------------------
// Accumulators
// ----------------------------------------
reg [2*IDX_W-1:0] line_ff;
reg [5:0] col_ff;
wire odd;
wire [2*IDX_W-1:0] line_mask;
wire [5:0] col_par;
wire [2*IDX_W-1:0] nxt_line;
wire [5:0] nxt_col;

assign odd = ^data;
assign col_par = {^(data & 8'hF0), ^(data & 8'h0F), ^(data & 8'hCC), ^(data & 8'h33),
                  ^(data & 8'hAA), ^(data & 8'h55)};

// Pair of line bits per address bit: one for set, one for clear
genvar g;
generate
   for (g = 0; g < IDX_W; g = g + 1) begin : g_line
      assign line_mask[2*g+1] = idx[g];
      assign line_mask[2*g] = ~idx[g];
   end
endgenerate

assign nxt_line = take ? (line_ff ^ (line_mask & {2*IDX_W{odd}})) : line_ff;
assign nxt_col = take ? (col_ff ^ col_par) : col_ff;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      line_ff <= {2*IDX_W{1'b0}};
      col_ff <= 6'h00;
   end else if (clk_en) begin
      if (clear) begin
         line_ff <= {2*IDX_W{1'b0}};
         col_ff <= 6'h00;
      end else begin
         line_ff <= nxt_line;
         col_ff <= nxt_col;
      end
   end
end

// Built from the next value, so the closing byte of a block is included
// Stored inverted so an erased block reads all ones
assign code = {~nxt_line, ~nxt_col};

endmodule
`default_nettype wire

// [rtl/iecc_top.v]
/*
 Interface code generator: watches the byte-wide interface data path and
 builds codes over 256- or 512-byte blocks; AHB-Lite register slave.
 Assumes the path strobe marks one byte per cycle in the hclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iecc_regs.vh"

module iecc_top (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire path_byte_valid,
   input wire [7:0] path_byte,
   input wire path_is_fifo
);

// ----------------------------------------
// Bus address phase capture
// ----------------------------------------
reg wr_pend_ff;
reg [`IECC_ADDR_BITS-1:0] addr_ff;
reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;
reg [1:0] ctrl_ff;
reg [1:0] nxt_ctrl;
reg [8:0] count_ff;
reg [8:0] nxt_count;
reg second_ff;
reg nxt_second;
reg done_ff;
reg nxt_done;
reg [`IECC_CODE_W-1:0] first_ff;
reg [`IECC_CODE_W-1:0] nxt_first;
reg [`IECC_CODE_W-1:0] second_res_ff;
reg [`IECC_CODE_W-1:0] nxt_second_res;
wire sel_nseq;
wire sel_read;
wire wr_ctrl;
wire restart;
wire take;
wire last_short;
wire last_long;
wire block_end;
wire par_clear;
wire mode_long;
wire width_word;
wire [`IECC_CODE_W-1:0] code_raw;
wire [`IECC_CODE_W-1:0] code_short;
wire [`IECC_CODE_W-1:0] code;

// ----------------------------------------
// Decode helpers
// ----------------------------------------
// True when a bus address names the given register word
function hit;
   input [`IECC_ADDR_BITS-1:0] addr;
   input [`IECC_ADDR_BITS-1:0] reg_addr;
   begin
      hit = (addr == reg_addr);
   end
endfunction

// ----------------------------------------
// Bus handshake
// ----------------------------------------
assign sel_nseq = hsel && hready && (htrans == `IECC_HTRANS_NSEQ);
assign sel_read = sel_nseq && !hwrite;

// Zero-wait slave: every transfer completes in its first data cycle
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_ff;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_pend_ff <= 1'b0;
   end else if (clk_en) begin
      wr_pend_ff <= sel_nseq && hwrite;
   end
end

// Address kept for the data phase, where the write data arrives
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      addr_ff <= {`IECC_ADDR_BITS{1'b0}};
   end else if (clk_en) begin
      addr_ff <= haddr[`IECC_ADDR_BITS-1:0];
   end
end

// ----------------------------------------
// Control writes
// ----------------------------------------
assign wr_ctrl = wr_pend_ff && hit(addr_ff, `IECC_ADDR_CTRL);
assign restart = wr_pend_ff && hit(addr_ff, `IECC_ADDR_RESTART);

always @* begin
   nxt_ctrl = ctrl_ff;
   if (wr_ctrl) begin
      nxt_ctrl[`IECC_CTRL_MODE_BIT] = hwdata[`IECC_CTRL_MODE_BIT];
      nxt_ctrl[`IECC_CTRL_WIDE_BIT] = hwdata[`IECC_CTRL_WIDE_BIT];
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      ctrl_ff <= `IECC_CTRL_RESET;
   end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
   end
end

assign mode_long = ctrl_ff[`IECC_CTRL_MODE_BIT];
assign width_word = ctrl_ff[`IECC_CTRL_WIDE_BIT];

// ----------------------------------------
// Block sequencing
// ----------------------------------------
// Word-wide traffic is ignored: the code is defined over bytes only
// A byte in the restart write's data cycle is dropped; the restart wins
assign take = path_byte_valid && !width_word && !done_ff && !restart;
assign last_short = (count_ff == `IECC_LAST_SHORT);
assign last_long = (count_ff == `IECC_LAST_LONG);
assign block_end = take && (mode_long ? last_long : last_short);

// Limitation: changing the mode inside a block needs a restart afterwards
always @* begin
   nxt_count = count_ff;
   if (restart) begin
      nxt_count = 9'h000;
   end else if (block_end) begin
      nxt_count = 9'h000;
   end else if (take) begin
      nxt_count = count_ff + 9'h001;
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      count_ff <= 9'h000;
   end else if (clk_en) begin
      count_ff <= nxt_count;
   end
end

always @* begin
   nxt_second = second_ff;
   nxt_done = done_ff;
   if (restart) begin
      nxt_second = 1'b0;
      nxt_done = 1'b0;
   end else if (block_end) begin
      if (mode_long) begin
         nxt_done = 1'b1;
      end else if (!second_ff) begin
         nxt_second = 1'b1;
      end else begin
         nxt_done = 1'b1;
      end
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      second_ff <= 1'b0;
   end else if (clk_en) begin
      second_ff <= nxt_second;
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      done_ff <= 1'b0;
   end else if (clk_en) begin
      done_ff <= nxt_done;
   end
end

// ----------------------------------------
// Result registers
// ----------------------------------------
// Results survive a restart, so software may still read the last codes
always @* begin
   nxt_first = first_ff;
   nxt_second_res = second_res_ff;
   if (block_end) begin
      if (mode_long) begin
         nxt_first = code;
      end else if (!second_ff) begin
         nxt_first = code;
      end else begin
         nxt_second_res = code;
      end
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      first_ff <= {`IECC_CODE_W{1'b1}};
   end else if (clk_en) begin
      first_ff <= nxt_first;
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      second_res_ff <= {`IECC_CODE_W{1'b1}};
   end else if (clk_en) begin
      second_res_ff <= nxt_second_res;
   end
end

// ----------------------------------------
// Parity engine; long mode uses nine index bits, short mode eight
// ----------------------------------------
assign par_clear = restart || block_end;

iecc_parity #(
   .IDX_W(9)
) u_par (
   .hclk(hclk),
   .hresetn(hresetn),
   .clk_en(clk_en),
   .clear(par_clear),
   .take(take),
   .idx(count_ff),
   .data(path_byte),
   .code(code_raw)
);

// Short blocks never set the top index bit, so that line pair is dropped
// and two spare ones fill the low end
assign code_short = {code_raw[`IECC_CODE_W-3:0], 2'b11};
assign code = mode_long ? code_raw : code_short;

// ----------------------------------------
// Read data
// ----------------------------------------
// Captured in the address phase so it stands for the whole data phase
always @* begin
   nxt_rdata = rdata_ff;
   if (sel_read) begin
      case (haddr[`IECC_ADDR_BITS-1:0])
         `IECC_ADDR_CTRL: begin
            nxt_rdata = {{30{1'b0}}, ctrl_ff};
         end
         `IECC_ADDR_FIRST: begin
            nxt_rdata = {{8{1'b0}}, first_ff};
         end
         `IECC_ADDR_SECOND: begin
            nxt_rdata = {{8{1'b0}}, second_res_ff};
         end
         `IECC_ADDR_STATUS: begin
            nxt_rdata = {{29{1'b0}}, path_is_fifo, done_ff, second_ff};
         end
         default: begin
            nxt_rdata = 32'h00000000;
         end
      endcase
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rdata_ff <= 32'h00000000;
   end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
   end
end

endmodule
`default_nettype wire

// [bench/iecc_properties.sv]
/* Bus-side checker for iecc_top.
 Assumes the bind below; one slave, so hready is hreadyout. */
`timescale 1ns/1ps
`default_nettype none
module iecc_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic path_is_fifo
);
   logic [12:0] ra_ff;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ra_ff <= 13'h0000;
      else ra_ff <= {htrans == 2'h2 && !hwrite, haddr[11:0]};
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_rdy; hreadyout; endproperty
   a_rdy: assert property (p_rdy) else $error("ready low");
   property p_ok; !hresp; endproperty
   a_ok: assert property (p_ok) else $error("bad resp");
   property p_hold; !ra_ff[12] |-> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_unmap; ra_ff > 13'h1010 |-> hrdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_ctrl; ra_ff == 13'h1000 |-> hrdata[31:2] == 30'h0; endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl spare");
   property p_pad1; ra_ff == 13'h1008 |-> hrdata[1:0] == 2'h3; endproperty
   a_pad1: assert property (p_pad1) else $error("pad one");
   property p_pad2; ra_ff == 13'h100C |-> hrdata[1:0] == 2'h3; endproperty
   a_pad2: assert property (p_pad2) else $error("pad two");
   property p_src; ra_ff == 13'h1010 |-> hrdata[2] == path_is_fifo; endproperty
   a_src: assert property (p_src) else $error("path bit");
endmodule
bind iecc_top iecc_props u_props (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hrdata, .hreadyout, .hresp,
   .path_is_fifo);
`default_nettype wire

// [bench/iecc_src.sv]
/* Byte source in place of the interface data path.
 Assumes the bench calls send between bus transfers. */
`timescale 1ns/1ps
`default_nettype none
module iecc_src (
   input wire logic hclk,
   output var logic path_byte_valid = 1'b0,
   output var logic [7:0] path_byte = 8'hFF
);
   // Zero bytes, fm at offset fk of every 256; idle data is inverted so it never looks valid
   task automatic send(input int n, input int fk, input logic [7:0] fm, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge hclk);
         path_byte_valid <= 1'b1;
         path_byte <= i % 256 == fk ? fm : 8'h00;
         repeat (gap) begin
            @(posedge hclk);
            path_byte_valid <= 1'b0;
            path_byte <= ~path_byte;
         end
      end
      @(posedge hclk);
      path_byte_valid <= 1'b0;
      path_byte <= ~path_byte;
   endtask
endmodule
`default_nettype wire

// [bench/tb_iecc_top.sv]
/* Bench for iecc_top: bus task, byte source, code checks.
 Assumes the bound checker and the byte source model. */
`timescale 1ns/1ps
`default_nettype none
module tb_iecc_top;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, path_is_fifo = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
   logic hreadyout, hresp, path_byte_valid;
   logic [7:0] path_byte;
   logic [31:0] hrdata;
   int n_mismatch = 0, n_checks = 0;
   iecc_top u_iecc_top (.hclk, .hresetn, .clk_en(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .path_byte_valid, .path_byte, .path_is_fifo);
   iecc_src u_iecc_src (.hclk, .path_byte_valid, .path_byte);
   initial forever #5 hclk = ~hclk;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(12'h004, 1, 0);
      u_iecc_src.send(99, 3, 8'h40, 0);
      bus(12'h004, 1, 0);
      u_iecc_src.send(256, 0, 8'h00, 1);
      u_iecc_src.send(512, 7, 8'h80, 0);
      bus(12'h008, 0, 0);
      check("first", v, 32'hFFFFFF);
      bus(12'h00C, 0, 0);
      check("second", $countones(v ^ 32'hFFFFFF), 11);
      bus(12'h000, 1, 32'h1);
      bus(12'h004, 1, 0);
      u_iecc_src.send(576, 5, 8'h04, 2);
      bus(12'h008, 0, 0);
      check("single", $countones(v ^ 32'hFFFFFF), 2);
      bus(12'h000, 1, 32'h2);
      bus(12'h004, 1, 0);
      u_iecc_src.send(9, 1, 8'h01, 0);
      bus(12'h010, 0, 0);
      check("status", v, 32'h4);
      bus(12'h020, 0, 0);
      check("unmapped", v, 32'h0);
      bus(12'h000, 0, 0);
      check("ctrl", v, 32'h2);
      close_out;
   end
endmodule
`default_nettype wire
